//--- data_address_generation_defs.vh
`ifndef DATA_ADDRESS_GENERATION_DEFS_VH
`define DATA_ADDRESS_GENERATION_DEFS_VH

// ----------------------------------------------------------------
// Pointer block locations (low byte of each block)
// ----------------------------------------------------------------
`define PTR0_BASE      12'hfe9
`define PTR1_BASE      12'hfe1
`define PTR2_BASE      12'hfd9

// ----------------------------------------------------------------
// Offsets within a pointer block
// ----------------------------------------------------------------
`define OFS_LOW        3'h0
`define OFS_HIGH       3'h1
`define OFS_ACC_OFS    3'h2
`define OFS_PRE_INC    3'h3
`define OFS_POST_DEC   3'h4
`define OFS_POST_INC   3'h5
`define OFS_PLAIN      3'h6
`define BLOCK_SPAN     12'h007

// ----------------------------------------------------------------
// Access bank split and banks
// ----------------------------------------------------------------
`define ACCESS_LOW_MAX 8'h5f
`define LOW_BANK       4'h0
`define SFR_BANK       4'hf
`define IMPL_BANKS     4'h8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PTR_RESET      12'h000
`define BYTE_RESET     8'h00
`define ADDR_RESET     12'h000

`endif

//--- data_address_generation.v
`timescale 1ns/1ns
`include "data_address_generation_defs.vh"

module data_address_generation (
	input  wire        ref_clk,
	input  wire        nrst,
	input  wire        req_valid,
	input  wire        req_write,
	input  wire        req_commit,
	input  wire        req_full,
	input  wire [11:0] req_full_addr,
	input  wire [7:0]  req_file_addr,
	input  wire        req_access_sel,
	input  wire        req_dest_sel,
	input  wire [7:0]  req_wdata,
	input  wire [3:0]  bank_select_value,
	input  wire [7:0]  accum_value,
	input  wire        extended_set_enable,
	input  wire [7:0]  mem_rdata,
	output reg  [11:0] mem_addr_q,
	output reg         mem_rd_q,
	output reg         mem_wr_q,
	output reg  [7:0]  mem_wdata_q,
	output reg         accum_we_q,
	output reg  [7:0]  accum_wdata_q,
	output reg  [7:0]  rdata_q,
	output reg         rdata_valid_q,
	output wire [11:0] data_pointer_0,
	output wire [11:0] data_pointer_1,
	output wire [11:0] data_pointer_2
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	reg  [11:0] ptr_q [0:2];
	wire [11:0] base  [0:2];
	wire [11:0] ind_part [0:2];
	wire [7:0]  pbyte_part [0:2];
	wire [2:0]  d_hit;
	wire [2:0]  d_virt;
	wire [2:0]  e_hit;
	wire [2:0]  e_virt;
	wire [2:0]  e_preg;
	wire [11:0] acc_ext;
	wire        low_ofs;
	reg  [11:0] dir_addr;
	wire [11:0] ind_addr;
	wire        indirect;
	wire [11:0] eff_addr;
	wire        eff_virtual;
	wire        eff_preg;
	wire [7:0]  preg_byte;
	wire        impl_bank;
	wire        rd_req;
	wire        file_wr;
	wire        accum_wr;
	wire        mem_ok;
	reg         from_mem_q;
	reg  [7:0]  rbyte_q;
	reg         rpend_q;

	assign base[0] = `PTR0_BASE;
	assign base[1] = `PTR1_BASE;
	assign base[2] = `PTR2_BASE;

	assign data_pointer_0 = ptr_q[0];
	assign data_pointer_1 = ptr_q[1];
	assign data_pointer_2 = ptr_q[2];

	// ------------------------------------------------------------
	// Direct address forming
	// ------------------------------------------------------------
	assign low_ofs = (req_file_addr <= `ACCESS_LOW_MAX);

	always @* begin
		if (req_full) begin
			dir_addr = req_full_addr;
		end else if (req_access_sel) begin
			dir_addr = {bank_select_value, req_file_addr};
		end else if (extended_set_enable && low_ofs) begin
			dir_addr = ptr_q[2] + {4'h0, req_file_addr};
		end else if (low_ofs) begin
			dir_addr = {`LOW_BANK, req_file_addr};
		end else begin
			dir_addr = {`SFR_BANK, req_file_addr};
		end
	end

	assign acc_ext = {{4{accum_value[7]}}, accum_value};

	// ------------------------------------------------------------
	// Per pointer decode, indirect address and update
	// ------------------------------------------------------------
	genvar n;
	generate
		for (n = 0; n < 3; n = n + 1) begin : g_ptr
			wire [11:0] d_off;
			wire [11:0] e_off;
			wire [2:0]  d_kind;
			wire [2:0]  e_kind;
			wire        wr_low;
			wire        wr_high;
			wire        self_wr;
			wire        bump;
			reg  [11:0] ptr_d;

			assign d_off  = dir_addr - base[n];
			assign d_kind = d_off[2:0];
			assign d_hit[n]  = (d_off < `BLOCK_SPAN);
			assign d_virt[n] = d_hit[n] && (d_kind >= `OFS_ACC_OFS);

			assign ind_part[n] = !d_virt[n] ? 12'h000 :
				(d_kind == `OFS_ACC_OFS) ? ptr_q[n] + acc_ext :
				(d_kind == `OFS_PRE_INC) ? ptr_q[n] + 12'h001 :
				ptr_q[n];

			assign e_off  = eff_addr - base[n];
			assign e_kind = e_off[2:0];
			assign e_hit[n]  = (e_off < `BLOCK_SPAN);
			assign e_virt[n] = e_hit[n] && (e_kind >= `OFS_ACC_OFS);
			assign e_preg[n] = e_hit[n] && (e_kind <= `OFS_HIGH);

			assign pbyte_part[n] = !e_preg[n] ? 8'h00 :
				(e_kind == `OFS_LOW) ? ptr_q[n][7:0] :
				{4'h0, ptr_q[n][11:8]};

			assign wr_low  = file_wr && e_preg[n] &&
				(e_kind == `OFS_LOW);
			assign wr_high = file_wr && e_preg[n] &&
				(e_kind == `OFS_HIGH);
			assign self_wr = wr_low || wr_high;
			assign bump = req_valid && req_commit && d_virt[n] &&
				(d_kind == `OFS_PRE_INC ||
				 d_kind == `OFS_POST_DEC ||
				 d_kind == `OFS_POST_INC);

			always @* begin
				ptr_d = ptr_q[n];
				if (wr_low) begin
					ptr_d = {ptr_q[n][11:8], req_wdata};
				end else if (wr_high) begin
					ptr_d = {req_wdata[3:0], ptr_q[n][7:0]};
				end else if (bump && !self_wr) begin
					if (d_kind == `OFS_POST_DEC) begin
						ptr_d = ptr_q[n] - 12'h001;
					end else begin
						ptr_d = ptr_q[n] + 12'h001;
					end
				end
			end

			// Update lands at the request edge; no flag output exists
			always @(posedge ref_clk) begin
				if (!nrst) begin
					ptr_q[n] <= `PTR_RESET;
				end else begin
					ptr_q[n] <= ptr_d;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Effective address and target class
	// ------------------------------------------------------------
	assign indirect  = |d_virt;
	assign ind_addr  = ind_part[0] | ind_part[1] | ind_part[2];
	assign eff_addr  = indirect ? ind_addr : dir_addr;
	assign eff_virtual = indirect && (|e_virt);
	assign eff_preg  = |e_preg;
	assign preg_byte = pbyte_part[0] | pbyte_part[1] | pbyte_part[2];
	assign impl_bank = (eff_addr[11:8] < `IMPL_BANKS) ||
		(eff_addr[11:8] == `SFR_BANK);

	assign rd_req   = req_valid && !req_write;
	assign file_wr  = req_valid && req_write && !eff_virtual &&
		(req_dest_sel || req_full);
	assign accum_wr = req_valid && req_write && !req_dest_sel &&
		!req_full;
	assign mem_ok   = !eff_virtual && !eff_preg && impl_bank;

	// ------------------------------------------------------------
	// Memory and accumulator strobes
	// ------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (!nrst) begin
			mem_addr_q    <= `ADDR_RESET;
			mem_rd_q      <= 1'b0;
			mem_wr_q      <= 1'b0;
			mem_wdata_q   <= `BYTE_RESET;
			accum_we_q    <= 1'b0;
			accum_wdata_q <= `BYTE_RESET;
		end else begin
			mem_addr_q    <= eff_addr;
			mem_rd_q      <= rd_req && mem_ok;
			mem_wr_q      <= file_wr && mem_ok;
			mem_wdata_q   <= req_wdata;
			accum_we_q    <= accum_wr;
			accum_wdata_q <= req_wdata;
		end
	end

	// ------------------------------------------------------------
	// Read return to the core
	// ------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (!nrst) begin
			from_mem_q    <= 1'b0;
			rbyte_q       <= `BYTE_RESET;
			rpend_q       <= 1'b0;
			rdata_q       <= `BYTE_RESET;
			rdata_valid_q <= 1'b0;
		end else begin
			rpend_q    <= rd_req;
			from_mem_q <= mem_ok;
			if (eff_virtual || !impl_bank) begin
				rbyte_q <= 8'h00;
			end else begin
				rbyte_q <= preg_byte;
			end
			rdata_valid_q <= rpend_q;
			if (rpend_q) begin
				rdata_q <= from_mem_q ? mem_rdata : rbyte_q;
			end
		end
	end

endmodule // data_address_generation

//--- data_memory_model.sv
`timescale 1ns/1ns
// ------
// Data SRAM seen by the address generator
// ------
module data_memory_model (
	input  wire        ref_clk,
	input  wire        mem_rd_q,
	input  wire        mem_wr_q,
	input  wire [11:0] mem_addr_q,
	input  wire [7:0]  mem_wdata_q,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [4096];
	logic [7:0] junk = 8'h00;
	always @(posedge ref_clk) begin
		junk <= junk + 8'h3b;
		if (mem_wr_q)
			mem[mem_addr_q] <= mem_wdata_q;
	end
	// Idle cycles show a changing pattern, not stale data
	assign mem_rdata = mem_rd_q ? mem[mem_addr_q] : junk;
endmodule // data_memory_model

//--- data_address_generation_props.sv
`timescale 1ns/1ns
// ------
// Port checker
// ------
module data_address_generation_props (
	input wire        ref_clk, nrst, req_valid, req_write, req_commit,
	input wire        req_full, req_access_sel, req_dest_sel,
	input wire        extended_set_enable, mem_rd_q, mem_wr_q,
	input wire        accum_we_q, rdata_valid_q,
	input wire [11:0] req_full_addr, mem_addr_q,
	input wire [11:0] data_pointer_0, data_pointer_1, data_pointer_2,
	input wire [7:0]  req_file_addr, req_wdata, accum_value, mem_rdata,
	input wire [7:0]  mem_wdata_q, accum_wdata_q, rdata_q,
	input wire [3:0]  bank_select_value
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	wire dir = req_valid && !req_full;
	wire unimpl = dir && req_access_sel && bank_select_value >= 4'h8
		&& bank_select_value != 4'hf;
	sequence s_unimpl_rd;
		unimpl && !req_write ##1 1'h1;
	endsequence
	sequence s_postinc0;
		dir && req_commit && !req_write && !req_access_sel
			&& req_file_addr == 8'hee;
	endsequence
	a_bank_read: assert property (
		dir && !req_write && req_access_sel && bank_select_value == 4'h0
		|=> mem_rd_q && mem_addr_q == {4'h0, $past(req_file_addr)})
		else $error("banked read address wrong");
	a_access_low: assert property (
		dir && req_dest_sel && !req_access_sel && !extended_set_enable
		&& req_file_addr <= 8'h5f |=> (mem_rd_q || mem_wr_q)
		&& mem_addr_q == {4'h0, $past(req_file_addr)})
		else $error("access bank low address wrong");
	a_full_addr: assert property (
		req_valid && req_full && req_full_addr < 12'h800
		|=> (mem_rd_q || mem_wr_q) && mem_addr_q == $past(req_full_addr))
		else $error("full address not used");
	a_file_wdata: assert property (
		dir && req_write && req_dest_sel && req_access_sel
		&& bank_select_value < 4'h8
		|=> mem_wr_q && mem_wdata_q == $past(req_wdata))
		else $error("file write data wrong");
	a_accum_dest: assert property (
		dir && req_write && !req_dest_sel |=> accum_we_q && !mem_wr_q
		&& accum_wdata_q == $past(req_wdata))
		else $error("accumulator write wrong");
	a_unimpl_quiet: assert property (
		unimpl |=> !mem_rd_q && !mem_wr_q)
		else $error("unimplemented bank strobed");
	a_unimpl_zero: assert property (
		s_unimpl_rd |=> rdata_valid_q && rdata_q == 8'h00)
		else $error("unimplemented bank read not zero");
	a_read_data: assert property (
		mem_rd_q |=> rdata_valid_q && rdata_q == $past(mem_rdata))
		else $error("read data not returned");
	a_post_inc: assert property (
		s_postinc0 |=> data_pointer_0 == $past(data_pointer_0) + 12'h001)
		else $error("post increment wrong");
	a_ptr_idle: assert property (
		!req_valid |=> $stable(data_pointer_0) && $stable(data_pointer_1)
		&& $stable(data_pointer_2))
		else $error("pointer moved while idle");
endmodule // data_address_generation_props

//--- data_address_generation_bench.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin \
	comparisons++; \
	if ((g) !== (e)) begin \
		n_errors++; \
		$display("CHECK FAILED %s exp %h got %h", n, e, g); \
	end \
end
module data_address_generation_bench;
	logic        ref_clk = 1'h0, nrst, req_valid, req_write, req_commit;
	logic        req_full, req_access_sel, req_dest_sel, extended_set_enable;
	logic [11:0] req_full_addr, k;
	logic [7:0]  req_file_addr, req_wdata, accum_value;
	logic [3:0]  bank_select_value;
	wire  [7:0]  mem_rdata, mem_wdata_q, accum_wdata_q, rdata_q;
	wire  [11:0] mem_addr_q, data_pointer_0, data_pointer_1, data_pointer_2;
	wire         mem_rd_q, mem_wr_q, accum_we_q, rdata_valid_q;
	int          n_errors = 0;
	int          comparisons = 0;
	logic [7:0]  sb [logic [11:0]];
	data_address_generation u_dut (.*);
	data_memory_model u_mem (.*);
	always #5 ref_clk = ~ref_clk;
	task automatic conclude;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic op(input logic wr, ac, input logic [7:0] fl, dt);
		@(negedge ref_clk);
		{req_valid, req_write, req_access_sel} = {1'h1, wr, ac};
		{req_file_addr, req_wdata} = {fl, dt};
		@(negedge ref_clk);
		req_valid = 1'h0;
	endtask
	task automatic rd(input logic ac, input logic [7:0] fl, e);
		int i;
		op(1'h0, ac, fl, 8'h00);
		for (i = 0; i < 4 && rdata_valid_q !== 1'h1; i++)
			@(negedge ref_clk);
		if (i == 4) begin
			n_errors++;
			conclude;
		end
		`CHK("rdata", e, rdata_q)
	endtask
	task automatic setp(input logic [7:0] lo, input logic [11:0] v);
		op(1'h1, 1'h0, lo, v[7:0]);
		op(1'h1, 1'h0, lo + 8'h01, {4'ha, v[11:8]});
	endtask
	initial begin
		{nrst, req_valid, req_write, req_full, req_access_sel} = '0;
		{extended_set_enable, req_full_addr, req_file_addr} = '0;
		{req_wdata, accum_value, bank_select_value} = '0;
		{req_commit, req_dest_sel} = 2'h3;
		k = 12'($urandom(32'hbabe9c56));
		repeat (20) @(negedge ref_clk);
		nrst = 1'h1;
		`CHK("ptr0", 12'h000, data_pointer_0)
		for (int j = 0; j < 24; j++) begin
			bank_select_value = 4'($urandom % 8);
			k = {bank_select_value, 8'($urandom)};
			sb[k] = 8'($urandom);
			op(1'h1, 1'h1, k[7:0], sb[k]);
		end
		{req_full, bank_select_value} = 5'h1c;
		foreach (sb[ad]) begin
			req_full_addr = ad;
			rd(1'h0, 8'h00, sb[ad]);
		end
		{req_full, bank_select_value} = 5'h05;
		op(1'h1, 1'h0, 8'h30, 8'h6d);
		bank_select_value = 4'h0;
		rd(1'h1, 8'h30, 8'h6d);
		op(1'h1, 1'h0, 8'h80, 8'h39);
		bank_select_value = 4'hf;
		rd(1'h1, 8'h80, 8'h39);
		setp(8'he9, 12'h1ff);
		`CHK("ptr0", 12'h1ff, data_pointer_0)
		op(1'h1, 1'h0, 8'hef, 8'ha1);
		`CHK("ptr0", 12'h1ff, data_pointer_0)
		{req_full, req_full_addr} = {1'h1, 12'h200};
		op(1'h1, 1'h0, 8'h00, 8'hb2);
		req_full = 1'h0;
		rd(1'h0, 8'hee, 8'ha1);
		`CHK("ptr0", 12'h200, data_pointer_0)
		rd(1'h0, 8'hed, 8'hb2);
		`CHK("ptr0", 12'h1ff, data_pointer_0)
		rd(1'h0, 8'hec, 8'hb2);
		accum_value = 8'hff;
		rd(1'h0, 8'heb, 8'ha1);
		`CHK("ptr0", 12'h200, data_pointer_0)
		bank_select_value = 4'h9;
		op(1'h1, 1'h1, 8'h10, 8'h77);
		rd(1'h1, 8'h10, 8'h00);
		req_dest_sel = 1'h0;
		op(1'h1, 1'h1, 8'h10, 8'h5e);
		req_dest_sel = 1'h1;
		setp(8'he1, 12'hfe1);
		op(1'h1, 1'h0, 8'he6, 8'h44);
		`CHK("ptr1", 12'hf44, data_pointer_1)
		setp(8'he1, 12'hfef);
		rd(1'h0, 8'he7, 8'h00);
		op(1'h1, 1'h0, 8'he7, 8'h55);
		`CHK("ptr0", 12'h200, data_pointer_0)
		`CHK("ptr1", 12'hfef, data_pointer_1)
		setp(8'hd9, 12'h120);
		`CHK("ptr2", 12'h120, data_pointer_2)
		extended_set_enable = 1'h1;
		op(1'h1, 1'h0, 8'h05, 8'hc3);
		rd(1'h0, 8'hef, 8'hb2);
		{extended_set_enable, req_full, req_full_addr} = {2'h1, 12'h125};
		rd(1'h0, 8'h00, 8'hc3);
		conclude;
	end
endmodule // data_address_generation_bench
bind data_address_generation data_address_generation_props u_props (.*);
